// ===== bench/dram_row_model.sv
`timescale 1ns/1ps
module dram_row_model
(
   input  wire       clk,
   input  wire       firstPin,
   input  wire       secondPin,
   output reg  [1:0] seenPins
);
   always @(posedge clk)
      seenPins <= {secondPin, firstPin};
endmodule // dram_row_model

// ===== bench/row_type_chk.sv
`timescale 1ns/1ps
module row_type_chk
(
   input wire       clk,
   input wire       arst_n,
   input wire [7:0] regAddr,
   input wire [7:0] regWrData,
   input wire       regWrite,
   input wire       regRead,
   input wire [7:0] regRdData,
   input wire       cke0In,
   input wire       cke1In,
   input wire       memAddr0,
   input wire       memAddr1,
   input wire       firstClockEnablePin,
   input wire       secondClockEnablePin,
   input wire       hostFreqIndicator,
   input wire       cycleRequest,
   input wire       cycleStart
);
   reg copyEn;
   wire typeWr = regWrite && regAddr == 8'h67;
   wire typeRd = regRead && regAddr == 8'h67;
   always @(posedge clk or negedge arst_n)
      if (!arst_n) copyEn <= 1'b0;
      else if (typeWr) copyEn <= regWrData[2];
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence s_typeWrite; typeWr; endsequence
   property p_rdIdle; !regRead |=> regRdData == 8'h00; endproperty
   property p_resv; typeRd |=> !regRdData[6] && !regRdData[3]; endproperty
   property p_hfdWr; s_typeWrite |=> hostFreqIndicator == $past(regWrData[7]); endproperty
   property p_hfdRd; typeRd |=> regRdData[7] == $past(hostFreqIndicator); endproperty
   property p_copyRd; typeRd |=> regRdData[2] == $past(copyEn); endproperty
   property p_start; cycleStart == cycleRequest; endproperty
   property p_copyOn;
      copyEn |=> {secondClockEnablePin, firstClockEnablePin} == $past({memAddr1, memAddr0});
   endproperty
   property p_copyOff;
      !copyEn |=> {secondClockEnablePin, firstClockEnablePin} == $past({cke1In, cke0In});
   endproperty
   a_rdIdle: assert property (p_rdIdle) else $error("idle read data");
   a_resv: assert property (p_resv) else $error("reserved bits");
   a_hfdWr: assert property (p_hfdWr) else $error("freq bit write");
   a_hfdRd: assert property (p_hfdRd) else $error("freq bit read");
   a_copyRd: assert property (p_copyRd) else $error("copy enable read");
   a_start: assert property (p_start) else $error("cycle start");
   a_copyOn: assert property (p_copyOn) else $error("pins not address");
   a_copyOff: assert property (p_copyOff) else $error("pins not clock enable");
endmodule // row_type_chk

// ===== bench/testbench.sv
`timescale 1ns/1ps
`include "row_type_defs.vh"
module testbench;
   reg        clk = 0;
   reg        arst_n = 0;
   reg  [7:0] regAddr = 8'h00;
   reg  [7:0] regWrData = 8'h00;
   reg        regWrite = 0;
   reg        regRead = 0;
   reg        strap = 0;
   reg        cycleRequest = 0;
   reg  [6:0] cycleAddr = 7'h00;
   reg        refreshOn = 0;
   reg  [3:0] pinIn = 4'h9;
   wire [7:0] regRdData;
   wire [1:0] cycleKind, seenPins;
   wire       cycleRowHit, cycleIsRow5, hazard, firstPin, secondPin, r4Sd, r5Sd;
   integer    n_fail = 0;
   integer    tests_run = 0;
   integer    k;
   dram_row_type_high_config dram_row_type_high_config_i
   (
      .clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .strapAddr27(strap),
      .cycleRequest(cycleRequest), .cycleAddr(cycleAddr), .cycleStart(),
      .cycleRowHit(cycleRowHit), .cycleKind(cycleKind), .cycleIsRow5(cycleIsRow5),
      .refreshEnabled(refreshOn), .refreshWriteHazard(hazard), .cke0In(pinIn[0]),
      .cke1In(pinIn[1]), .memAddr0(pinIn[2]), .memAddr1(pinIn[3]),
      .firstClockEnablePin(firstPin), .secondClockEnablePin(secondPin),
      .hostFreqIndicator(), .row4IsSdram(r4Sd), .row5IsSdram(r5Sd)
   );
   dram_row_model dram_row_model_i
      (.clk(clk), .firstPin(firstPin), .secondPin(secondPin), .seenPins(seenPins));
   initial forever #2 clk = ~clk;
   task chk(input [7:0] got, input [7:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp)
         begin
            n_fail = n_fail + 1;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(posedge clk);
         regWrite <= 1;
         regAddr <= a;
         regWrData <= d;
         @(posedge clk);
         regWrite <= 0;
      end
   endtask
   task rd(input [7:0] a, input [7:0] e);
      begin
         @(posedge clk);
         regRead <= 1;
         regAddr <= a;
         @(posedge clk);
         regRead <= 0;
         #1 chk(regRdData, e);
      end
   endtask
   task cyc(input [6:0] a, input [3:0] e);
      begin
         @(posedge clk);
         cycleRequest <= 1;
         cycleAddr <= a;
         @(posedge clk);
         cycleRequest <= 0;
         #1 chk({4'h0, cycleRowHit, cycleIsRow5, cycleKind}, {4'h0, e});
      end
   endtask
   task pins(input [7:0] e);
      begin
         repeat (3) @(posedge clk);
         #1 chk({6'h00, seenPins}, e);
      end
   endtask
   task test_done;
      begin
         $display("comparisons %0d mismatches %0d", tests_run, n_fail);
         if (n_fail == 0 && tests_run > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   initial
   begin
      #5000 n_fail = n_fail + 1;
      test_done;
   end
   initial
   begin
      repeat (5) @(posedge clk);
      arst_n <= 1;
      rd(`ROW_TYPE_OFFSET, 8'h80);
      rd(8'h10, 8'h00);
      wr(`ROW_TYPE_OFFSET, 8'hFF);
      rd(`ROW_TYPE_OFFSET, 8'hB7);
      wr(`ROW_TYPE_OFFSET, 8'h00);
      rd(`ROW_TYPE_OFFSET, 8'h00);
      $display("register test done");
      pins(8'h01);
      wr(`ROW_TYPE_OFFSET, 8'h04);
      pins(8'h02);
      $display("pin test done");
      wr(`ROW_BOUND3_OFFSET, 8'h02);
      wr(`ROW_BOUND4_OFFSET, 8'h04);
      rd(`ROW_BOUND5_OFFSET, 8'h04);
      wr(`ROW_BOUND5_OFFSET, 8'h06);
      rd(`ROW_BOUND4_OFFSET, 8'h04);
      for (k = 0; k < 4; k = k + 1)
      begin
         wr(`ROW_TYPE_OFFSET, {2'b00, k[1], k[1], 2'b00, k[0], k[0]});
         cyc(7'h03, {2'b10, k[1:0]});
         cyc(7'h05, {2'b11, k[1:0]});
         chk({6'h00, r5Sd, r4Sd}, {6'h00, {2{k == 2}}});
      end
      cyc(7'h06, 4'h0);
      $display("row kind test done");
      wr(`ROW_TYPE_OFFSET, 8'h04);
      strap <= 1;
      arst_n <= 0;
      repeat (5) @(posedge clk);
      arst_n <= 1;
      rd(`ROW_TYPE_OFFSET, 8'h00);
      pins(8'h01);
      @(posedge clk);
      refreshOn <= 1;
      wr(`ROW_TYPE_OFFSET, 8'h00);
      #1 chk({7'h00, hazard}, 8'h01);
      $display("strap and refresh test done");
      test_done;
   end
endmodule // testbench
bind dram_row_type_high_config row_type_chk row_type_chk_i
(
   .clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
   .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .cke0In(cke0In),
   .cke1In(cke1In), .memAddr0(memAddr0), .memAddr1(memAddr1),
   .firstClockEnablePin(firstClockEnablePin), .secondClockEnablePin(secondClockEnablePin),
   .hostFreqIndicator(hostFreqIndicator), .cycleRequest(cycleRequest), .cycleStart(cycleStart)
);

// ===== logic/clock_enable_mux.v
`timescale 1ns/1ps
module clock_enable_mux
(
   input  wire clk,
   input  wire arst_n,
   input  wire addrCopyEnable,
   input  wire cke0In,
   input  wire cke1In,
   input  wire memAddr0,
   input  wire memAddr1,
   output reg  firstClockEnablePin,
   output reg  secondClockEnablePin
);
   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         firstClockEnablePin  <= 1'b0;
         secondClockEnablePin <= 1'b0;
      end
      else if (addrCopyEnable)
      begin
         firstClockEnablePin  <= memAddr0;
         secondClockEnablePin <= memAddr1;
      end
      else
      begin
         firstClockEnablePin  <= cke0In;
         secondClockEnablePin <= cke1In;
      end
   end
endmodule // clock_enable_mux

// ===== logic/dram_row_type_high_config.v
// Operation
// - bit 7 reads 1 for 66 MHz host bus, 0 for 60 MHz.
// - at reset release bit 7 loads the inverse of strap address 27.
// - strap pin has weak pull-down, so bit 7 defaults to 1.
// - software write to bit 7 overrides strap until next write or reset.
// - row 5 kind is bits 5,1; row 4 kind is bits 4,0.
// - kind 00 page mode, 01 EDO, 10 SDRAM, 11 reserved.
// - cycle timing latched from accessed row's kind as the cycle starts, valid one clock later.
// - copy enable 1: clock-enable pins carry address bits 0 and 1.
// - copy enable 0: clock-enable pins carry normal clock-enable.
// - copy enable resets to 0; software sets it to use copies.
// - rows 4 and 5 bounded by fifth and sixth boundaries, 4 MB units.
`timescale 1ns/1ps
`include "row_type_defs.vh"
module dram_row_type_high_config
(
   input  wire       clk,
   input  wire       arst_n,
   input  wire [7:0] regAddr,
   input  wire [7:0] regWrData,
   input  wire       regWrite,
   input  wire       regRead,
   output reg  [7:0] regRdData,
   input  wire       strapAddr27,
   input  wire       cycleRequest,
   input  wire [6:0] cycleAddr,
   output wire       cycleStart,
   output reg        cycleRowHit,
   output reg  [1:0] cycleKind,
   output reg        cycleIsRow5,
   input  wire       refreshEnabled,
   output reg        refreshWriteHazard,
   input  wire       cke0In,
   input  wire       cke1In,
   input  wire       memAddr0,
   input  wire       memAddr1,
   output wire       firstClockEnablePin,
   output wire       secondClockEnablePin,
   output wire       hostFreqIndicator,
   output wire       row4IsSdram,
   output wire       row5IsSdram
);
   reg  [7:0] rowTypeUpper;
   reg  [6:0] rowBound3;
   reg  [6:0] rowBound4;
   reg  [6:0] rowBound5;
   reg        strapPending;
   wire [1:0] row4Kind;
   wire [1:0] row5Kind;
   wire       inRow4;
   wire       inRow5;
   wire       wrType;

   function isAddr;
      input [7:0] addr;
      input [7:0] target;
      begin
         isAddr = (addr == target);
      end
   endfunction

   assign wrType = regWrite && isAddr(regAddr, `ROW_TYPE_OFFSET);

   assign row5Kind = {rowTypeUpper[`ROW5_HIGH_BIT], rowTypeUpper[`ROW5_LOW_BIT]};
   assign row4Kind = {rowTypeUpper[`ROW4_HIGH_BIT], rowTypeUpper[`ROW4_LOW_BIT]};

   assign hostFreqIndicator = rowTypeUpper[`HOST_FREQ_BIT];

   // register file; strap capture on the first clock after release
   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rowTypeUpper <= `ROW_TYPE_RESET;
         strapPending <= 1'b1;
         rowBound3    <= `ROW_BOUND_RESET;
         rowBound4    <= `ROW_BOUND_RESET;
         rowBound5    <= `ROW_BOUND_RESET;
      end
      else
      begin
         strapPending <= 1'b0;
         if (wrType)
            rowTypeUpper <= regWrData & `ROW_TYPE_WMASK;
         else if (strapPending)
            rowTypeUpper[`HOST_FREQ_BIT] <= ~strapAddr27;
         if (regWrite && isAddr(regAddr, `ROW_BOUND3_OFFSET))
         begin
            rowBound3 <= regWrData[6:0];
            rowBound4 <= regWrData[6:0];
            rowBound5 <= regWrData[6:0];
         end
         else if (regWrite && isAddr(regAddr, `ROW_BOUND4_OFFSET))
         begin
            rowBound4 <= regWrData[6:0];
            rowBound5 <= regWrData[6:0];
         end
         else if (regWrite && isAddr(regAddr, `ROW_BOUND5_OFFSET))
            rowBound5 <= regWrData[6:0];
      end
   end

   // read port, data one cycle after strobe
   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         regRdData <= 8'h00;
      else if (regRead)
      begin
         if (isAddr(regAddr, `ROW_TYPE_OFFSET))
            regRdData <= rowTypeUpper;
         else if (isAddr(regAddr, `ROW_BOUND3_OFFSET))
            regRdData <= {1'b0, rowBound3};
         else if (isAddr(regAddr, `ROW_BOUND4_OFFSET))
            regRdData <= {1'b0, rowBound4};
         else if (isAddr(regAddr, `ROW_BOUND5_OFFSET))
            regRdData <= {1'b0, rowBound5};
         else
            regRdData <= 8'h00;
      end
      else
         regRdData <= 8'h00;
   end

   // flag for a type write during refresh, held until refresh is disabled
   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         refreshWriteHazard <= 1'b0;
      else if (wrType && refreshEnabled)
         refreshWriteHazard <= 1'b1;
      else if (!refreshEnabled)
         refreshWriteHazard <= 1'b0;
   end

   // row 4 spans bound3..bound4, row 5 bound4..bound5, 4 MB units
   assign inRow4 = (cycleAddr >= rowBound3) && (cycleAddr < rowBound4);
   assign inRow5 = (cycleAddr >= rowBound4) && (cycleAddr < rowBound5);
   assign cycleStart = cycleRequest;

   // timing kind latched as the cycle is requested
   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cycleRowHit <= 1'b0;
         cycleKind   <= `KIND_PAGE;
         cycleIsRow5 <= 1'b0;
      end
      else if (cycleRequest)
      begin
         cycleRowHit <= inRow4 | inRow5;
         cycleIsRow5 <= inRow5;
         cycleKind   <= inRow5 ? row5Kind : (inRow4 ? row4Kind : `KIND_PAGE);
      end
   end

   row_kind_decode row4Decode
   (
      .kindCode   (row4Kind),
      .isPage     (),
      .isEdo      (),
      .isSdram    (row4IsSdram),
      .isReserved ()
   );

   row_kind_decode row5Decode
   (
      .kindCode   (row5Kind),
      .isPage     (),
      .isEdo      (),
      .isSdram    (row5IsSdram),
      .isReserved ()
   );

   clock_enable_mux pinMux
   (
      .clk                  (clk),
      .arst_n               (arst_n),
      .addrCopyEnable       (rowTypeUpper[`ADDR_COPY_BIT]),
      .cke0In               (cke0In),
      .cke1In               (cke1In),
      .memAddr0             (memAddr0),
      .memAddr1             (memAddr1),
      .firstClockEnablePin  (firstClockEnablePin),
      .secondClockEnablePin (secondClockEnablePin)
   );
endmodule // dram_row_type_high_config

// ===== logic/row_kind_decode.v
`timescale 1ns/1ps
`include "row_type_defs.vh"
module row_kind_decode
(
   input  wire [1:0] kindCode,
   output reg        isPage,
   output reg        isEdo,
   output reg        isSdram,
   output reg        isReserved
);
   // one-hot decode of a two-bit row kind
   always @*
   begin
      isPage     = 1'b0;
      isEdo      = 1'b0;
      isSdram    = 1'b0;
      isReserved = 1'b0;
      case (kindCode)
         `KIND_PAGE:  isPage = 1'b1;
         `KIND_EDO:   isEdo = 1'b1;
         `KIND_SDRAM: isSdram = 1'b1;
         default:     isReserved = 1'b1;
      endcase
   end
endmodule // row_kind_decode

// ===== logic/row_type_defs.vh
`ifndef ROW_TYPE_DEFS_VH
`define ROW_TYPE_DEFS_VH
`define ROW_TYPE_OFFSET    8'h67
`define ROW_BOUND4_OFFSET  8'h64
`define ROW_BOUND5_OFFSET  8'h65
`define ROW_BOUND3_OFFSET  8'h63
`define HOST_FREQ_BIT      7
`define ROW5_HIGH_BIT      5
`define ROW4_HIGH_BIT      4
`define ADDR_COPY_BIT      2
`define ROW5_LOW_BIT       1
`define ROW4_LOW_BIT       0
`define ROW_TYPE_WMASK     8'hB7
`define ROW_TYPE_RESET     8'h00
`define ROW_BOUND_RESET    7'h02
`define KIND_PAGE          2'h0
`define KIND_EDO           2'h1
`define KIND_SDRAM         2'h2
`define KIND_RESERVED      2'h3
`endif
